/* File: rtl/recorder_timing_pkg.sv */
/*
  Shared constants of the recorder timing generator: clock rates, pulse
  widths, delays and counter widths. Assumes a single 25 MHz system clock.
*/
package recorder_timing_pkg;
  // System clock
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  // Crystal reference rate, made as an enable from the system clock
  localparam int REF_HZ = 38_400;
  localparam int REF_DIV_CYCLES = (CLK_HZ + REF_HZ / 2) / REF_HZ;
  localparam int REF_CNT_W = 10;
  // Base tick divider: default ratio and counter width
  localparam int BASE_RATIO_W = 14;
  localparam logic [13:0] BASE_RATIO_DEFAULT = 14'h2580;
  // Slower binary-divided ticks
  localparam int SLOW_TICKS = 7;
  // Delay of the delayed gated tick, in cycles
  localparam int GATE_DELAY_CYCLES = 2;
  // Load and counter-clear pulse width
  localparam int LOAD_PULSE_NS = 16_000;
  localparam int LOAD_PULSE_CYCLES = (LOAD_PULSE_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int LOAD_CNT_W = 9;
  // Shift clock delay
  localparam int SHIFT_DELAY_US = 500;
  localparam int SHIFT_DELAY_CYCLES = (SHIFT_DELAY_US * 1000 + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int EDGE_QUEUE_DEPTH = 32;
  // Power-on pulse
  localparam int POWER_ON_S = 10;
  localparam int POWER_ON_CYCLES = POWER_ON_S * CLK_HZ;
  localparam int POWER_CNT_W = 28;
endpackage

/* File: rtl/pulse_timer.sv */
/*
  Non-retriggerable one-shot: a trigger starts a pulse of CYCLES clock
  cycles; done marks its last cycle. Trigger is from the same clock.
*/
`timescale 1ns/1ps
module pulse_timer #(
  parameter int CYCLES = 400,
  parameter int CW = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Trigger and pulse
  input wire logic trig,
  output logic active,
  output logic done
);
  logic [CW-1:0] count;

  // Last cycle of the pulse
  assign done = active && (count == CW'(CYCLES - 1));

  // Triggers during a pulse are ignored, like the one-shot it replaces
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      count <= '0;
    end else if (!active) begin
      active <= trig;
      count <= '0;
    end else if (done) begin
      active <= 1'b0;
    end else begin
      count <= count + CW'(1);
    end
  end
endmodule // pulse_timer

/* File: rtl/recorder_timing_generator.sv */
/*
  Recorder timing generator: base and slower ticks, gated tick, word load
  and clear pulses, delayed shift clock and power-on timing. Assumes one
  25 MHz clock; all logger and sequencer inputs are asynchronous pins.
*/
`timescale 1ns/1ps
module recorder_timing_generator
  import recorder_timing_pkg::*;
#(
  parameter int SHIFT_DELAY = SHIFT_DELAY_CYCLES,
  parameter int POWER_ON = POWER_ON_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Divider setting
  input wire logic [BASE_RATIO_W-1:0] base_ratio,
  // Ticks
  output logic base_tick,
  output logic [SLOW_TICKS-1:0] slow_tick,
  output logic gated_tick,
  output logic delayed_gated_tick,
  // Logger and sequencer inputs (asynchronous)
  input wire logic logger_gap_busy,
  input wire logic digital_start,
  input wire logic logger_write_clock,
  input wire logic record_gap_signal,
  input wire logic digital_select,
  // Data card strobes
  output logic shift_load_pulse,
  output logic counter_clear_pulse,
  output logic delayed_shift_clock,
  // Power-up
  output logic power_on_pulse,
  output logic tape_load_forward
);
  localparam int TS_W = $clog2(SHIFT_DELAY + 1) + 1;
  localparam int QA_W = $clog2(EDGE_QUEUE_DEPTH);

  logic [4:0] sync1, sync2, sync3, pin;
  logic gap_f, start_f, wclk_f, rgap_f, dsel_f;
  logic ref_en;
  logic [REF_CNT_W-1:0] ref_cnt;
  logic [BASE_RATIO_W-1:0] base_cnt;
  logic [SLOW_TICKS-1:0] slow_cnt;
  logic [GATE_DELAY_CYCLES-1:0] gate_dly;
  logic start_q, load_done, clear_done;
  logic burst, burst_q, push, pop;
  logic [TS_W-1:0] now, head;
  logic [TS_W-1:0] edge_mem [EDGE_QUEUE_DEPTH];
  logic [QA_W:0] wr_ptr, rd_ptr;
  logic [POWER_CNT_W-1:0] por_cnt;

  assign {gap_f, start_f, wclk_f, rgap_f, dsel_f} = pin;

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin <= '0;
    end else begin
      sync1 <= {logger_gap_busy, digital_start, logger_write_clock, record_gap_signal,
                digital_select};
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= (sync2 & sync3) | (pin & (sync2 ^ sync3));
    end
  end

  // Reference-rate enable standing in for the crystal oscillator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt <= '0;
      ref_en <= 1'b0;
    end else begin
      ref_en <= (ref_cnt == REF_CNT_W'(REF_DIV_CYCLES - 1));
      ref_cnt <= (ref_cnt == REF_CNT_W'(REF_DIV_CYCLES - 1)) ? '0 : ref_cnt + REF_CNT_W'(1);
    end
  end

  // Programmable base divider; a ratio of zero acts as one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      base_cnt <= '0;
      base_tick <= 1'b0;
    end else begin
      base_tick <= 1'b0;
      if (ref_en) begin
        if (base_cnt + BASE_RATIO_W'(1) >= base_ratio) begin
          base_cnt <= '0;
          base_tick <= 1'b1;
        end else begin
          base_cnt <= base_cnt + BASE_RATIO_W'(1);
        end
      end
    end
  end

  // Mask of the low k+1 chain bits; avoids a variable-width part-select
  function automatic logic [SLOW_TICKS-1:0] low_ones(input int k);
    low_ones = (SLOW_TICKS'(1) << (k + 1)) - SLOW_TICKS'(1);
  endfunction

  // Binary chain: tick k fires every 2^(k+1) base ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slow_cnt <= '0;
      slow_tick <= '0;
    end else begin
      for (int k = 0; k < SLOW_TICKS; k++) begin
        slow_tick[k] <= base_tick && ((slow_cnt & low_ones(k)) == low_ones(k));
      end
      if (base_tick) begin
        slow_cnt <= slow_cnt + SLOW_TICKS'(1);
      end
    end
  end

  // Gated tick and its delayed copy; the delay gives sequencer data time to settle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gated_tick <= 1'b0;
      gate_dly <= '0;
    end else begin
      gated_tick <= base_tick && !gap_f;
      gate_dly <= {gate_dly[GATE_DELAY_CYCLES-2:0], gated_tick};
    end
  end
  assign delayed_gated_tick = gate_dly[GATE_DELAY_CYCLES-1];

  // Start edge detector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_f;
    end
  end

  // Load then clear one-shots; a start edge during the load is ignored
  pulse_timer #(.CYCLES(LOAD_PULSE_CYCLES), .CW(LOAD_CNT_W)) load_timer (
    .clk(clk),
    .rstn(rstn),
    .trig(start_f && !start_q),
    .active(shift_load_pulse),
    .done(load_done)
  );
  pulse_timer #(.CYCLES(LOAD_PULSE_CYCLES), .CW(LOAD_CNT_W)) clear_timer (
    .clk(clk),
    .rstn(rstn),
    .trig(load_done),
    .active(counter_clear_pulse),
    .done(clear_done)
  );

  // Word burst, only forwarded while digital data is recorded
  assign burst = wclk_f && rgap_f && dsel_f;
  assign push = (burst != burst_q) && (wr_ptr - rd_ptr != (QA_W + 1)'(EDGE_QUEUE_DEPTH));
  assign head = edge_mem[rd_ptr[QA_W-1:0]];
  assign pop = (wr_ptr != rd_ptr) && (now - head == TS_W'(SHIFT_DELAY));

  // Edge time queue: burst edges, up to 32 waiting, are replayed SHIFT_DELAY cycles later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_q <= 1'b0;
      now <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      delayed_shift_clock <= 1'b0;
    end else begin
      burst_q <= burst;
      now <= now + TS_W'(1);
      if (push) begin
        wr_ptr <= wr_ptr + (QA_W + 1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (QA_W + 1)'(1);
        delayed_shift_clock <= !delayed_shift_clock;
      end
    end
  end

  // Queue storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      edge_mem[wr_ptr[QA_W-1:0]] <= now;
    end
  end

  // Power-on timer; the end of the pulse raises tape_load_forward
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt <= '0;
      power_on_pulse <= 1'b1;
      tape_load_forward <= 1'b0;
    end else if (power_on_pulse) begin
      por_cnt <= por_cnt + POWER_CNT_W'(1);
      if (por_cnt == POWER_CNT_W'(POWER_ON - 1)) begin
        power_on_pulse <= 1'b0;
        tape_load_forward <= 1'b1;
      end
    end
  end

  // Helper counters for the checks below
  logic [31:0] base_gap, load_len, clear_len;
  logic base_seen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      base_gap <= '0;
      base_seen <= 1'b0;
      load_len <= '0;
      clear_len <= '0;
    end else begin
      base_gap <= base_tick ? 32'h1 : base_gap + 32'h1;
      base_seen <= base_seen || base_tick;
      load_len <= shift_load_pulse ? load_len + 32'h1 : 32'h0;
      clear_len <= counter_clear_pulse ? clear_len + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  base_period_a: assert property ($stable(base_ratio) && base_tick && base_seen && base_ratio > 1
    |-> base_gap == REF_DIV_CYCLES * base_ratio) else $error("base tick period wrong");
  slow_tick_a: assert property (|slow_tick |-> $past(base_tick))
    else $error("slow tick without base tick");
  gate_block_a: assert property (gated_tick |-> $past(base_tick) && !$past(gap_f))
    else $error("gated tick during file gap");
  delay_copy_a: assert property (gated_tick |-> ##2 delayed_gated_tick)
    else $error("delayed gated tick missing");
  load_start_a: assert property ($rose(start_f) && !shift_load_pulse |=> shift_load_pulse)
    else $error("load pulse did not start");
  // Length counter already holds the full width on the cycle the fall is seen
  load_width_a: assert property ($fell(shift_load_pulse) |-> load_len == LOAD_PULSE_CYCLES)
    else $error("load pulse width wrong");
  clear_follow_a: assert property ($fell(shift_load_pulse) |-> $rose(counter_clear_pulse))
    else $error("clear did not follow load");
  clear_width_a: assert property ($fell(counter_clear_pulse)
    |-> clear_len == LOAD_PULSE_CYCLES) else $error("clear pulse width wrong");
  burst_mask_a: assert property (!dsel_f |-> !burst && !push || burst_q)
    else $error("burst forwarded in analog mode");
  power_on_a: assert property ($fell(power_on_pulse) |-> $past(por_cnt) == POWER_ON - 1)
    else $error("power-on pulse length wrong");
  tape_inverse_a: assert property (tape_load_forward == !power_on_pulse)
    else $error("tape command not inverse of power-on");

  load_clear_c: cover property ($fell(counter_clear_pulse));
  burst_fwd_c: cover property (push && burst);
  shift_out_c: cover property ($rose(delayed_shift_clock));
  gap_block_c: cover property (base_tick && gap_f);
endmodule // recorder_timing_generator

/* File: dv/recorder_partner.sv */
/*
  Model of the logger, sequencer and data cards facing the timing generator.
  Assumes the bench calls its tasks from the clock domain of clk.
*/
`timescale 1ns/1ps
module recorder_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Strobes from the generator
  input wire logic gated_tick,
  input wire logic shift_load_pulse,
  input wire logic counter_clear_pulse,
  input wire logic delayed_shift_clock,
  // Logger and sequencer lines
  output logic logger_write_clock,
  output logic record_gap_signal,
  output logic digital_start
);
  int steps;
  int loads;
  int shifts;
  logic last_load;
  logic last_shift;
  initial begin
    logger_write_clock = 1'b0;
    record_gap_signal = 1'b0;
    digital_start = 1'b0;
  end
  // Card and sequencer bookkeeping, edges found against the last level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      steps <= 0;
      loads <= 0;
      shifts <= 0;
      last_load <= 1'b0;
      last_shift <= 1'b0;
    end else begin
      last_load <= shift_load_pulse;
      last_shift <= delayed_shift_clock;
      if (gated_tick) steps <= steps + 1;
      if (shift_load_pulse && !last_load) loads <= loads + 1;
      if (counter_clear_pulse) shifts <= 0;
      else if (delayed_shift_clock && !last_shift) shifts <= shifts + 1;
    end
  end
  // Start of a digital word, held long enough to pass the synchroniser
  task automatic start_word();
    @(posedge clk) digital_start <= 1'b1;
    repeat (10) @(posedge clk);
    digital_start <= 1'b0;
  endtask
  // Word window with n write clocks; slow pulses keep the sync happy
  task automatic word(input int n);
    @(posedge clk) record_gap_signal <= 1'b1;
    repeat (n) begin
      repeat (3) @(posedge clk);
      logger_write_clock <= 1'b1;
      repeat (3) @(posedge clk);
      logger_write_clock <= 1'b0;
    end
    repeat (3) @(posedge clk);
    record_gap_signal <= 1'b0;
  endtask
endmodule // recorder_partner

/* File: dv/recorder_timing_generator_test.sv */
/*
  Self-checking bench of the recorder timing generator and its far side.
  Assumes short SHIFT_DELAY and POWER_ON values to keep the run brief.
*/
`timescale 1ns/1ps
module recorder_timing_generator_test;
  import recorder_timing_pkg::*;
  localparam int SD = 20;
  localparam int PO = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [BASE_RATIO_W-1:0] base_ratio = 14'h0001;
  logic logger_gap_busy = 1'b0;
  logic digital_select = 1'b0;
  logic base_tick, gated_tick, delayed_gated_tick, digital_start;
  logic logger_write_clock, record_gap_signal, shift_load_pulse, counter_clear_pulse;
  logic delayed_shift_clock, power_on_pulse, tape_load_forward;
  logic [SLOW_TICKS-1:0] slow_tick;
  logic [5:0] probe;
  int fails = 0;
  int compares = 0;
  int c;
  int d;
  assign probe = {delayed_shift_clock, logger_write_clock, counter_clear_pulse,
                  shift_load_pulse, power_on_pulse, base_tick};
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  recorder_timing_generator #(.SHIFT_DELAY(SD), .POWER_ON(PO)) u_recorder_timing_generator (
    .clk(clk), .rstn(rstn), .base_ratio(base_ratio), .base_tick(base_tick),
    .slow_tick(slow_tick), .gated_tick(gated_tick), .delayed_gated_tick(delayed_gated_tick),
    .logger_gap_busy(logger_gap_busy), .digital_start(digital_start),
    .logger_write_clock(logger_write_clock), .record_gap_signal(record_gap_signal),
    .digital_select(digital_select), .shift_load_pulse(shift_load_pulse),
    .counter_clear_pulse(counter_clear_pulse), .delayed_shift_clock(delayed_shift_clock),
    .power_on_pulse(power_on_pulse), .tape_load_forward(tape_load_forward));
  recorder_partner u_recorder_partner (
    .clk(clk), .rstn(rstn), .gated_tick(gated_tick), .shift_load_pulse(shift_load_pulse),
    .counter_clear_pulse(counter_clear_pulse), .delayed_shift_clock(delayed_shift_clock),
    .logger_write_clock(logger_write_clock), .record_gap_signal(record_gap_signal),
    .digital_start(digital_start));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Sampling on the falling edge keeps clear of the launch edge
  task automatic high_len(input int b, output int n);
    n = 0;
    while (probe[b] !== 1'b1) @(negedge clk);
    while (probe[b] === 1'b1) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic tick_gap(output int n);
    high_len(0, n);
    n = 1;
    while (base_tick !== 1'b1) begin
      n++;
      @(negedge clk);
    end
  endtask
  // Power-on pulse from reset, then tape command as its inverse
  task automatic t_power();
    @(negedge clk);
    check("power in reset", power_on_pulse, 1);
    check("tape in reset", tape_load_forward, 0);
    @(posedge clk) rstn <= 1'b1;
    high_len(1, c);
    check("power width", (c >= PO - 1 && c <= PO + 1), 1);
    check("tape after power", tape_load_forward, 1);
  endtask
  // Base period at two ratios and the binary chain below it
  task automatic t_ticks();
    tick_gap(c);
    check("base period r1", c, REF_DIV_CYCLES);
    @(posedge clk) base_ratio <= 14'h0002;
    tick_gap(c);
    tick_gap(c);
    check("base period r2", c, 2 * REF_DIV_CYCLES);
    @(posedge clk) base_ratio <= 14'h0001;
    tick_gap(c);
    c = 0;
    d = 0;
    repeat (8 * REF_DIV_CYCLES) begin
      @(negedge clk);
      c += slow_tick[0];
      d += slow_tick[1];
    end
    check("slow bit0 count", c, 4);
    check("slow bit1 count", d, 2);
  endtask
  // Gap blocks the gated tick; without it the tick and its echo appear
  task automatic t_gate();
    @(posedge clk) logger_gap_busy <= 1'b1;
    tick_gap(c);
    c = u_recorder_partner.steps;
    repeat (2 * REF_DIV_CYCLES) @(negedge clk);
    check("gated during gap", u_recorder_partner.steps, c);
    @(posedge clk) logger_gap_busy <= 1'b0;
    tick_gap(c);
    @(negedge clk);
    check("gated after base", gated_tick, 1);
    repeat (2) @(negedge clk);
    check("delayed gated", delayed_gated_tick, 1);
  endtask
  // Load then clear, each 16 us, the clear starting as the load ends
  task automatic t_load();
    fork
      u_recorder_partner.start_word();
      high_len(2, c);
    join
    check("clear follows load", counter_clear_pulse, 1);
    check("load width", c, LOAD_PULSE_CYCLES);
    high_len(3, c);
    check("clear width", c, LOAD_PULSE_CYCLES);
    check("words loaded", u_recorder_partner.loads, 1);
  endtask
  // Burst forwarded late when digital, dropped when analog
  task automatic t_burst();
    @(posedge clk) digital_select <= 1'b1;
    fork
      u_recorder_partner.word(16);
      begin
        high_len(4, c);
        d = 0;
        while (delayed_shift_clock !== 1'b1 && d < 200) begin
          d++;
          @(negedge clk);
        end
      end
    join
    repeat (SD + 20) @(negedge clk);
    check("shift delay", (d >= SD - 2 && d <= SD + 6), 1);
    check("shift count", u_recorder_partner.shifts, 16);
    @(posedge clk) digital_select <= 1'b0;
    u_recorder_partner.word(16);
    repeat (SD + 20) @(negedge clk);
    check("analog no shift", u_recorder_partner.shifts, 16);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    t_power();
    t_ticks();
    t_gate();
    t_load();
    t_burst();
    final_report();
  end
  // Watchdog well past the expected run length
  initial begin
    #(CLK_PERIOD_NS * 60000);
    fails++;
    final_report();
  end
endmodule // recorder_timing_generator_test
